// >>> src/hbdc_pkg.sv
// package: register map, field layout and timing for the h-bridge controller
package hbdc_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_DUTY   = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ST = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] OFS_IRQ_CL = 8'h18;

    // ----------------------------------------------------------------
    // ctrl fields
    // ----------------------------------------------------------------
    localparam int CTRL_EN    = 0;
    localparam int CTRL_MODE  = 1;
    localparam int CTRL_SIGN  = 2;
    localparam int CTRL_BRAKE = 3;
    localparam int CTRL_COAST = 4;

    // ----------------------------------------------------------------
    // irq bits
    // ----------------------------------------------------------------
    localparam int IRQ_WARN_SET = 0;
    localparam int IRQ_WARN_CLR = 1;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [4:0]  RST_CTRL   = 5'h00;
    localparam logic [15:0] RST_PERIOD = 16'h0064;
    localparam logic [15:0] RST_DUTY   = 16'h0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ       = 20_000_000;
    localparam int CLK_NS       = 50;
    localparam int EDGE_GAP_NS  = 1000;
    localparam int EDGE_GAP_CYC = (EDGE_GAP_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        MODE_SIGN_MAG = 2'h0,
        MODE_ANTI     = 2'h1
    } hbdc_mode_t;

    typedef struct packed {
        logic dir;
        logic brake;
        logic pwm;
    } hbdc_pins_t;

endpackage

// >>> src/hbdc_pin_pacer.sv
// one paced device pin: holds every transition for the minimum gap
`timescale 1ns/1ps
module hbdc_pin_pacer #(
    parameter int GAP = 20
) (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_want,
    input  wire logic i_grant,
    output logic      o_req,
    output logic      o_pin
);
    if (GAP < 1) begin : gap_chk
        $error("gap must be at least one cycle");
    end

    // pin moves only when the shared gap timer grants it
    assign o_req = (i_want != o_pin);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pin <= 1'b0;
        end else if (o_req && i_grant) begin
            o_pin <= i_want;
        end
    end
endmodule

// >>> src/hbdc_ctrl.sv
// host controller: apb registers, pwm generation, paced pins, warning irq
`timescale 1ns/1ps
module hbdc_ctrl #(
    parameter int GAP = hbdc_pkg::EDGE_GAP_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        i_warn_n,
    output logic             o_dir,
    output logic             o_brake,
    output logic             o_pwm,
    output logic             o_irq
);
    // gap timer is only 16 bits wide
    if (GAP < 1 || GAP > 65536) begin : gap_chk
        $error("gap must be 1 to 65536 cycles");
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [4:0]  ctrl_q;
    logic [15:0] period_q;
    logic [15:0] duty_q;
    logic [1:0]  irq_st_q;
    logic [1:0]  irq_en_q;
    logic        wr_en;
    logic        rd_en;
    logic        hit;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    always_comb begin
        case (paddr)
            hbdc_pkg::OFS_CTRL, hbdc_pkg::OFS_PERIOD, hbdc_pkg::OFS_DUTY,
            hbdc_pkg::OFS_STATUS, hbdc_pkg::OFS_IRQ_ST,
            hbdc_pkg::OFS_IRQ_EN, hbdc_pkg::OFS_IRQ_CL: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_q   <= hbdc_pkg::RST_CTRL;
            period_q <= hbdc_pkg::RST_PERIOD;
            duty_q   <= hbdc_pkg::RST_DUTY;
            irq_en_q <= 2'h0;
        end else if (wr_en) begin
            case (paddr)
                hbdc_pkg::OFS_CTRL:   ctrl_q   <= pwdata[4:0];
                hbdc_pkg::OFS_PERIOD: period_q <= pwdata[15:0];
                hbdc_pkg::OFS_DUTY:   duty_q   <= pwdata[15:0];
                hbdc_pkg::OFS_IRQ_EN: irq_en_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // warning input sync and irq
    // ----------------------------------------------------------------
    logic warn_s1_q;
    logic warn_s2_q;
    logic warn_d_q;
    logic warn_act;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            warn_s1_q <= 1'b1;
            warn_s2_q <= 1'b1;
            warn_d_q  <= 1'b1;
        end else begin
            warn_s1_q <= i_warn_n;
            warn_s2_q <= warn_s1_q;
            warn_d_q  <= warn_s2_q;
        end
    end
    assign warn_act = !warn_s2_q;

    logic [1:0] ev;
    logic [1:0] clr;
    assign ev  = {warn_s2_q && !warn_d_q, !warn_s2_q && warn_d_q};
    assign clr = (wr_en && paddr == hbdc_pkg::OFS_IRQ_CL) ?
                 pwdata[1:0] : 2'h0;

    // set wins over clear
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_st_q <= 2'h0;
        end else begin
            irq_st_q <= (irq_st_q & ~clr) | ev;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(((irq_st_q & ~clr) | ev) & irq_en_q);
        end
    end

    // ----------------------------------------------------------------
    // apb read and answer: always zero wait
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    hbdc_pkg::OFS_CTRL:   prdata <= {27'h0, ctrl_q};
                    hbdc_pkg::OFS_PERIOD: prdata <= {16'h0, period_q};
                    hbdc_pkg::OFS_DUTY:   prdata <= {16'h0, duty_q};
                    hbdc_pkg::OFS_STATUS:
                        prdata <= {28'h0, o_pwm, o_brake, o_dir, warn_act};
                    hbdc_pkg::OFS_IRQ_ST: prdata <= {30'h0, irq_st_q};
                    hbdc_pkg::OFS_IRQ_EN: prdata <= {30'h0, irq_en_q};
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // pwm carrier: period counts of the 20 mhz clock
    // ----------------------------------------------------------------
    logic [15:0] cnt_q;
    logic        duty_hi;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q + 16'h0001 >= period_q) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    // period below two gaps cannot be paced faithfully; pacer stretches
    assign duty_hi = (cnt_q < duty_q);

    // ----------------------------------------------------------------
    // pin intent from mode
    // ----------------------------------------------------------------
    hbdc_pkg::hbdc_pins_t want;
    logic en;
    assign en = ctrl_q[hbdc_pkg::CTRL_EN];

    always_comb begin
        want = '{dir: 1'b0, brake: 1'b1, pwm: 1'b0};
        if (!en || (warn_act && ctrl_q[hbdc_pkg::CTRL_COAST])) begin
            want = '{dir: 1'b0, brake: 1'b1, pwm: 1'b0};
        end else if (ctrl_q[hbdc_pkg::CTRL_BRAKE]) begin
            // sign picks high-side or low-side short
            want = '{dir: ctrl_q[hbdc_pkg::CTRL_SIGN], brake: 1'b1,
                     pwm: 1'b1};
        end else if (ctrl_q[hbdc_pkg::CTRL_MODE]) begin
            want = '{dir: duty_hi, brake: 1'b0, pwm: 1'b1};
        end else begin
            want = '{dir: ctrl_q[hbdc_pkg::CTRL_SIGN], brake: 1'b0,
                     pwm: duty_hi};
        end
    end

    // ----------------------------------------------------------------
    // shared gap timer: one pin edge per gap, across all three pins
    // ----------------------------------------------------------------
    logic [15:0] gap_q;
    logic [2:0]  req;
    logic [2:0]  grant;
    logic        ready;

    assign ready = (gap_q == 16'h0000);
    always_comb begin
        grant = 3'h0;
        if (ready) begin
            if (req[1])      grant = 3'h2; // brake first, safest
            else if (req[2]) grant = 3'h4;
            else if (req[0]) grant = 3'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gap_q <= 16'h0000;
        end else if (|grant) begin
            gap_q <= 16'(GAP - 1);
        end else if (!ready) begin
            gap_q <= gap_q - 16'h0001;
        end
    end

    hbdc_pin_pacer #(.GAP(GAP)) u_dir (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_want(want.dir),
        .i_grant(grant[0]), .o_req(req[0]), .o_pin(o_dir));
    hbdc_pin_pacer #(.GAP(GAP)) u_brake (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_want(want.brake),
        .i_grant(grant[1]), .o_req(req[1]), .o_pin(o_brake));
    hbdc_pin_pacer #(.GAP(GAP)) u_pwm (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_want(want.pwm),
        .i_grant(grant[2]), .o_req(req[2]), .o_pin(o_pwm));
endmodule

// >>> dv/hbdc_dev_model.sv
// bridge device model: pin decode, thermal flag, shutdown overrides
`timescale 1ns/1ps
module hbdc_dev_model (
    input  wire logic       i_dir,
    input  wire logic       i_brake,
    input  wire logic       i_pwm,
    input  wire logic [7:0] i_temp,
    input  wire logic       i_ocur,
    output logic      [3:0] o_drv,
    output logic            o_flag_oe_n,
    output logic            o_sense
);
    // ------------------------------------------------------------
    // drivers as {source1, sink1, source2, sink2}
    // ------------------------------------------------------------
    logic [3:0] dec;
    always_comb begin
        case ({i_pwm, i_brake})
            2'b10:   dec = i_dir ? 4'h9 : 4'h6;
            2'b00:   dec = 4'ha;
            2'b11:   dec = i_dir ? 4'ha : 4'h5;
            default: dec = 4'h0;
        endcase
    end
    // overrides win; no latch, so it runs again once the fault clears
    assign o_drv = (i_temp >= 8'haa || i_ocur) ? 4'h0 : dec;
    // flag transistor pulls low from 145 C, outputs keep running
    assign o_flag_oe_n = !(i_temp >= 8'h91);
    // sense follows the sourcing switches only; low-side brake current unseen
    assign o_sense = o_drv[3] | o_drv[1];
endmodule

// >>> dv/hbdc_ctrl_assertions.sv
// checker: pin pacing and bus handshake of the controller
`timescale 1ns/1ps
module hbdc_ctrl_chk #(
    parameter int GAP = 20
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic o_dir,
    input wire logic o_brake,
    input wire logic o_pwm,
    input wire logic o_irq
);
    logic [2:0] prv_q;
    int         cnt_q;
    wire  [2:0] pins = {o_dir, o_brake, o_pwm};
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prv_q <= 3'h0;
            cnt_q <= GAP;
        end else begin
            prv_q <= pins;
            cnt_q <= (pins != prv_q) ? 1 : (cnt_q < GAP ? cnt_q + 1 : GAP);
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_pin_gap: assert property (pins != prv_q |-> cnt_q >= GAP)
        else $error("pin edge too soon after the last");
    a_one_pin: assert property ($countones(pins ^ prv_q) <= 1)
        else $error("two pins changed together");
    a_ready_ans: assert property (psel && !penable |=> pready)
        else $error("no answer in access phase");
    a_ready_one: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_qual: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_err_qual: assert property (pslverr |-> pready)
        else $error("error without ready");
    c_pin_edge: cover property (pins != prv_q);
    c_refused: cover property (pslverr);
    c_irq: cover property ($rose(o_irq));
endmodule
bind hbdc_ctrl hbdc_ctrl_chk #(.GAP(GAP)) chk_u (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .o_dir(o_dir), .o_brake(o_brake), .o_pwm(o_pwm),
    .o_irq(o_irq));

// >>> dv/testbench.sv
// testbench: bus tasks driving the controller against the device model
`timescale 1ns/1ps
module testbench;
    logic        i_clk = 0, i_sys_rst = 1, psel = 0, penable = 0;
    logic        pwrite = 0, ocur = 0, pready, pslverr, err;
    logic        o_dir, o_brake, o_pwm, o_irq, oe_n, sense;
    logic [7:0]  paddr = 8'h00, temp = 8'h19;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0]  drv;
    wire         warn_n = oe_n ? 1'b1 : 1'b0;
    int          fail_count = 0, compares = 0, n, m;
    always #25 i_clk = ~i_clk;
    hbdc_ctrl #(.GAP(2)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_warn_n(warn_n), .o_dir(o_dir),
        .o_brake(o_brake), .o_pwm(o_pwm), .o_irq(o_irq));
    hbdc_dev_model dev_u (.i_dir(o_dir), .i_brake(o_brake), .i_pwm(o_pwm),
        .i_temp(temp), .i_ocur(ocur), .o_drv(drv), .o_flag_oe_n(oe_n),
        .o_sense(sense));
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        if (fail_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, x);
        compares++;
        if (s !== x) begin
            fail_count++;
            $display("FAIL %s exp %h got %h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        // pready is taken at the rising edge that also lands the write
        for (k = 0; k < 50; k++) begin
            @(posedge i_clk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin
            chk("ready", 0, 1);
            wrap_up();
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge i_clk);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(4);
        i_sys_rst <= 1'b0;
        apb(0, hbdc_pkg::OFS_PERIOD, 0);
        chk("period", r, {16'h0, hbdc_pkg::RST_PERIOD});
        apb(0, 8'h1c, 0);
        chk("unmapped", {r[30:0], err}, 32'h1);
        cyc(20);
        chk("coast", drv, 4'h0);
        apb(1, hbdc_pkg::OFS_CTRL, 32'hd);
        cyc(20);
        chk("brake pins", {o_brake, o_pwm}, 2'h3);
        chk("brake hi", drv, 4'ha);
        apb(1, hbdc_pkg::OFS_CTRL, 32'h9);
        cyc(20);
        chk("brake lo", drv, 4'h5);
        chk("sense sink", sense, 0);
        apb(1, hbdc_pkg::OFS_DUTY, 0);
        apb(1, hbdc_pkg::OFS_CTRL, 32'h5);
        cyc(20);
        chk("zero mag", drv, 4'ha);
        apb(1, hbdc_pkg::OFS_DUTY, 32'h64);
        cyc(20);
        chk("fwd", drv, 4'h9);
        chk("sense src", sense, 1);
        apb(1, hbdc_pkg::OFS_CTRL, 32'h1);
        cyc(20);
        chk("rev", drv, 4'h6);
        apb(1, hbdc_pkg::OFS_DUTY, 32'h32);
        apb(1, hbdc_pkg::OFS_CTRL, 32'h3);
        cyc(20);
        n = 0;
        m = 0;
        repeat (400) begin
            @(negedge i_clk);
            n += (o_dir === 1'b1);
            m += (o_pwm !== 1'b1);
        end
        chk("anti pwm", m, 0);
        chk("anti half", n > 180 && n < 220, 1);
        apb(1, hbdc_pkg::OFS_IRQ_EN, 32'h1);
        temp <= 8'h96;
        cyc(10);
        chk("irq on", o_irq, 1);
        chk("warm run", drv != 4'h0, 1);
        apb(0, hbdc_pkg::OFS_IRQ_ST, 0);
        chk("irq st", r, 32'h1);
        apb(1, hbdc_pkg::OFS_IRQ_CL, 32'h1);
        cyc(2);
        chk("irq clr", o_irq, 0);
        apb(1, hbdc_pkg::OFS_CTRL, 32'h13);
        cyc(20);
        chk("warn coast", drv, 4'h0);
        apb(0, hbdc_pkg::OFS_STATUS, 0);
        chk("status", r, 32'h5);
        apb(1, hbdc_pkg::OFS_CTRL, 32'h3);
        cyc(20);
        chk("warm back", drv != 4'h0, 1);
        temp <= 8'hb4;
        cyc(4);
        chk("hot off", drv, 4'h0);
        temp <= 8'h19;
        cyc(10);
        apb(0, hbdc_pkg::OFS_IRQ_ST, 0);
        chk("released", r, 32'h2);
        chk("masked", o_irq, 0);
        ocur <= 1'b1;
        cyc(2);
        chk("ocur", drv, 4'h0);
        ocur <= 1'b0;
        cyc(2);
        chk("retry", drv != 4'h0, 1);
        wrap_up();
    end
endmodule
